// ### hdl/stop_clock_defs.vh
// register offsets, field positions, reset values and timing counts for the stop-clock block
`ifndef STOP_CLOCK_DEFS_VH
`define STOP_CLOCK_DEFS_VH

// register indices reached through the index/data port pair
`define GENERAL_OUTPUT_OFS 8'h7B
`define STOP_CLOCK_CONTROL_OFS 8'h7C
`define DOZE_READBACK_OFS 8'h88
`define STANDBY_READBACK_OFS 8'h89
`define SUSPEND_READBACK_OFS 8'h8A
`define HOUSEKEEPING_READBACK_OFS 8'h8B
`define PERIPHERAL_READBACK_OFS 8'h8C

// reset values
`define GENERAL_OUTPUT_RESET 8'h00
`define STOP_CLOCK_CONTROL_RESET 8'h00
`define DOZE_READBACK_RESET 8'h00

// stop_clock_control fields
`define HALT_DUTY_MSB 7
`define HALT_DUTY_LSB 5
`define POWERDOWN_DUTY_MSB 4
`define POWERDOWN_DUTY_LSB 2
`define PERIOD_SELECT_BIT 1

// power_state_unit state codes
`define STATE_POWER_ON 3'h0
`define STATE_DOZE 3'h1
`define STATE_STANDBY 3'h2
`define STATE_SUSPEND 3'h3
`define STATE_DOZE_HK 3'h5
`define STATE_STANDBY_HK 3'h6

// duty codes
`define DUTY_NEVER 3'h0
`define DUTY_FULL 3'h7

// modulation period: 64 ms for either value of the select bit
`define PERIOD_SEL0_MS 64
`define PERIOD_SEL1_MS 64
`define CLOCK_MHZ 100
`define PERIOD_SEL0_CYCLES (`PERIOD_SEL0_MS * 1000 * `CLOCK_MHZ)
`define PERIOD_SEL1_CYCLES (`PERIOD_SEL1_MS * 1000 * `CLOCK_MHZ)

`endif

// ### hdl/stop_clock_modulation_regs.v
// stop-clock modulation, general output latch strobe and timer read-back registers
//
// Function
// - writing the general output register also loads the external output latch
// - reading the general output register returns the internal copy
// - latch select strobe pulses low for the cycle after a general output register write
// - bits 7-5 choose duty in power-on and house-keeping states
// - power-on field: 000 never, 001-110 halves to 1/64, 111 reserved
// - bits 4-2 choose duty in doze, standby and suspend
// - power-down field decodes alike, and 111 halts the whole period
// - a pending system-management interrupt holds the halt deasserted
// - bit 1 selects the modulation period, both printed as 64 ms
// - doze read-back at 88h returns doze timer bits 8-1
// - doze timer bit 0 is never readable
// - standby read-back shows 5-bit timer in bits 4-0, rest zero
// - suspend read-back shows 7-bit timer in bits 6-0, bit 7 zero
// - house-keeping read-back returns its timer bits 8-1
// - peripheral read-back returns its timer bits 8-1
// - control and doze read-back read 00h after reset; only control is reset, doze read-back returns live doze timer bits 8-1
// - three-bit power state picks which duty field applies
`timescale 1ns/1ns
`default_nettype none
`include "stop_clock_defs.vh"

module stop_clock_modulation_regs #(
   parameter PERIOD_SEL0_CYCLES = `PERIOD_SEL0_CYCLES,
   parameter PERIOD_SEL1_CYCLES = `PERIOD_SEL1_CYCLES
) (
   // clock and reset
   input wire i_clock,
   input wire i_sys_rst,
   // index/data register port, index already latched from the index port
   input wire [7:0] i_reg_index,
   input wire i_reg_write,
   input wire i_reg_read,
   input wire [7:0] i_reg_wdata,
   output reg [7:0] o_reg_rdata,
   // power state unit status
   input wire [2:0] i_power_state_unit,
   input wire i_smi_pending,
   // running timers
   input wire [8:0] i_doze_timer,
   input wire [4:0] i_standby_timer,
   input wire [6:0] i_suspend_timer,
   input wire [8:0] i_housekeeping_timer,
   input wire [8:0] i_peripheral_timer,
   // external output latch, fed from the isa data bus
   output reg o_output_latch_select_n,
   output reg [7:0] o_latch_data,
   // processor stop-clock
   output reg o_cpu_clock_halt_n
);

   reg [7:0] general_output_q;
   reg [7:0] stop_clock_control_q;
   reg [31:0] period_count_q;
   reg [31:0] period_count_d;
   reg [31:0] period_len;
   reg [2:0] duty_code;
   reg powerdown_state;
   reg halt_active;
   reg [7:0] rdata_d;
   reg [5:0] shift_sel;

   wire [2:0] halt_duty_field = stop_clock_control_q[`HALT_DUTY_MSB:`HALT_DUTY_LSB];
   wire [2:0] powerdown_duty_field = stop_clock_control_q[`POWERDOWN_DUTY_MSB:`POWERDOWN_DUTY_LSB];

   // register writes; bit 0 of the control register is reserved and kept zero
   always @(posedge i_clock) begin
      if (i_sys_rst) begin
         general_output_q <= `GENERAL_OUTPUT_RESET;
         stop_clock_control_q <= `STOP_CLOCK_CONTROL_RESET;
      end else if (i_reg_write) begin
         if (i_reg_index == `GENERAL_OUTPUT_OFS) begin
            general_output_q <= i_reg_wdata;
         end
         if (i_reg_index == `STOP_CLOCK_CONTROL_OFS) begin
            stop_clock_control_q <= {i_reg_wdata[7:1], 1'b0};
         end
      end
   end

   // latch strobe and data: one-cycle low pulse carrying the written byte
   always @(posedge i_clock) begin
      if (i_sys_rst) begin
         o_output_latch_select_n <= 1'b1;
         o_latch_data <= `GENERAL_OUTPUT_RESET;
      end else begin
         o_output_latch_select_n <= ~(i_reg_write && i_reg_index == `GENERAL_OUTPUT_OFS);
         if (i_reg_write && i_reg_index == `GENERAL_OUTPUT_OFS) begin
            o_latch_data <= i_reg_wdata;
         end
      end
   end

   // read multiplexer; unmapped indices read zero so other blocks can share the port
   always @* begin
      rdata_d = 8'h00;
      case (i_reg_index)
         `GENERAL_OUTPUT_OFS: rdata_d = general_output_q;
         `STOP_CLOCK_CONTROL_OFS: rdata_d = stop_clock_control_q;
         `DOZE_READBACK_OFS: rdata_d = i_doze_timer[8:1];
         `STANDBY_READBACK_OFS: rdata_d = {3'h0, i_standby_timer};
         `SUSPEND_READBACK_OFS: rdata_d = {1'b0, i_suspend_timer};
         `HOUSEKEEPING_READBACK_OFS: rdata_d = i_housekeeping_timer[8:1];
         `PERIPHERAL_READBACK_OFS: rdata_d = i_peripheral_timer[8:1];
         default: rdata_d = 8'h00;
      endcase
   end

   // read data registered; held until the next read
   always @(posedge i_clock) begin
      if (i_sys_rst) begin
         o_reg_rdata <= 8'h00;
      end else if (i_reg_read) begin
         o_reg_rdata <= rdata_d;
      end
   end

   // field selection by power state: doze, standby, suspend use the power-down field
   always @* begin
      case (i_power_state_unit)
         `STATE_DOZE, `STATE_STANDBY, `STATE_SUSPEND: powerdown_state = 1'b1;
         default: powerdown_state = 1'b0;
      endcase
      duty_code = powerdown_state ? powerdown_duty_field : halt_duty_field;
   end

   // period counter; both period settings print the same figure, kept separate
   always @* begin
      period_len = stop_clock_control_q[`PERIOD_SELECT_BIT] ? PERIOD_SEL1_CYCLES : PERIOD_SEL0_CYCLES;
      if (period_count_q >= period_len - 32'h1) begin
         period_count_d = 32'h0;
      end else begin
         period_count_d = period_count_q + 32'h1;
      end
   end

   always @(posedge i_clock) begin
      if (i_sys_rst) begin
         period_count_q <= 32'h0;
      end else begin
         period_count_q <= period_count_d;
      end
   end

   // halt window: first period/2^code cycles; reserved power-on 111 treated as never
   always @* begin
      shift_sel = 6'h00;
      halt_active = 1'b0;
      if (duty_code == `DUTY_FULL) begin
         halt_active = powerdown_state;
      end else if (duty_code != `DUTY_NEVER) begin
         shift_sel = {3'h0, duty_code};
         halt_active = period_count_q < (period_len >> shift_sel);
      end
      if (i_smi_pending) begin
         halt_active = 1'b0;
      end
   end

   // stop-clock output, active low
   always @(posedge i_clock) begin
      if (i_sys_rst) begin
         o_cpu_clock_halt_n <= 1'b1;
      end else begin
         o_cpu_clock_halt_n <= ~halt_active;
      end
   end

endmodule
`default_nettype wire

// ### test/stop_clock_modulation_regs_sva.sv
// port assertions for the stop-clock block
`timescale 1ns/1ns
`default_nettype none
module stop_clock_modulation_regs_sva (
   input wire logic i_clock, i_sys_rst, i_reg_write, i_reg_read, i_smi_pending,
   input wire logic [7:0] i_reg_index, i_reg_wdata, o_reg_rdata, o_latch_data,
   input wire logic [8:0] i_doze_timer,
   input wire logic [4:0] i_standby_timer,
   input wire logic [6:0] i_suspend_timer,
   input wire logic o_output_latch_select_n, o_cpu_clock_halt_n
);
   default clocking @(posedge i_clock); endclocking
   default disable iff (i_sys_rst);
   // decoded accesses
   wire gw = i_reg_write && i_reg_index == 8'h7B;
   wire rd = i_reg_read;
   // back-to-back writes keep the strobe low, so only a low strobe in the cycle after each write is required
   property p_pulse; gw |=> !o_output_latch_select_n; endproperty
   a_pulse: assert property (p_pulse) else $error("select pulse wrong");
   property p_quiet; !gw |=> o_output_latch_select_n; endproperty
   a_quiet: assert property (p_quiet) else $error("stray select");
   property p_data; gw |=> o_latch_data == $past(i_reg_wdata); endproperty
   a_data: assert property (p_data) else $error("latch byte wrong");
   property p_hold; !$stable(o_latch_data) |-> !o_output_latch_select_n; endproperty
   a_hold: assert property (p_hold) else $error("latch byte moved");
   property p_doze; rd && i_reg_index == 8'h88 |=> o_reg_rdata == $past(i_doze_timer) >> 1; endproperty
   a_doze: assert property (p_doze) else $error("doze read wrong");
   property p_stby; rd && i_reg_index == 8'h89 |=> o_reg_rdata == {3'h0, $past(i_standby_timer)}; endproperty
   a_stby: assert property (p_stby) else $error("standby read wrong");
   property p_susp; rd && i_reg_index == 8'h8A |=> o_reg_rdata == {1'b0, $past(i_suspend_timer)}; endproperty
   a_susp: assert property (p_susp) else $error("suspend read wrong");
   property p_smi; i_smi_pending |=> o_cpu_clock_halt_n; endproperty
   a_smi: assert property (p_smi) else $error("halt during smi");
endmodule
`default_nettype wire

// ### test/output_latch_model.sv
// external output latch and halted-cycle counter of the processor
`timescale 1ns/1ns
`default_nettype none
module output_latch_model (
   input wire logic i_clock, i_sel_n, i_halt_n,
   input wire logic [7:0] i_data,
   output logic [7:0] o_latched,
   output int o_halted
);
   initial o_halted = 0;
   // byte taken only while select is low
   always @(posedge i_clock) if (!i_sel_n) o_latched <= i_data;
   // the bench measures duty as a difference of this count
   always @(posedge i_clock) o_halted <= o_halted + 32'(!i_halt_n);
endmodule
`default_nettype wire

// ### test/tb_stop_clock_modulation_regs.sv
// self-checking bench for the stop-clock block
`timescale 1ns/1ns
`default_nettype none
module tb_stop_clock_modulation_regs;
   logic i_clock = 0, i_sys_rst = 1, i_reg_write = 0, i_reg_read = 0, i_smi_pending = 0, pend = 0, pd;
   logic [7:0] i_reg_index = 0, i_reg_wdata = 0, o_reg_rdata, o_latch_data, latched, d;
   logic [2:0] i_power_state_unit = 0;
   logic [8:0] i_doze_timer = 0, i_housekeeping_timer = 0, i_peripheral_timer = 0;
   logic [4:0] i_standby_timer = 0;
   logic [6:0] i_suspend_timer = 0;
   logic o_output_latch_select_n, o_cpu_clock_halt_n;
   logic [7:0] exp_q[$];
   int miscompares = 0, n_compared = 0, seed = 32'hA481, halted, h0, e, cycles = 0;
   // short period keeps the duty sweep quick
   stop_clock_modulation_regs #(.PERIOD_SEL0_CYCLES(64), .PERIOD_SEL1_CYCLES(64)) dut (.*);
   output_latch_model partner (.i_clock, .i_sel_n(o_output_latch_select_n), .i_halt_n(o_cpu_clock_halt_n),
      .i_data(o_latch_data), .o_latched(latched), .o_halted(halted));
   always #5 i_clock = ~i_clock;
   task cyc; @(posedge i_clock); #1; endtask
   task check(input logic [8:0] seen, exp);
      n_compared++;
      if (seen !== exp) begin miscompares++; $display("mismatch at %0t: %h not %h", $time, seen, exp); end
   endtask
   task wr(input logic [7:0] a, v); i_reg_index = a; i_reg_wdata = v; i_reg_write = 1; cyc; i_reg_write = 0; cyc; endtask
   task rd(input logic [7:0] a, v); exp_q.push_back(v); i_reg_index = a; i_reg_read = 1; cyc; i_reg_read = 0; cyc; endtask
   task print_verdict;
      $display("compared %0d, mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // read data settles one edge after the read is taken
   always @(negedge i_clock) begin
      if (pend) check(o_reg_rdata, exp_q.pop_front());
      pend = i_reg_read;
   end
   always @(posedge i_clock) if (++cycles == 20000) begin miscompares++; print_verdict; end
   initial begin
      repeat (4) cyc;
      i_sys_rst = 0;
      rd(8'h7C, 8'h00); rd(8'h88, 8'h00);
      d = $random(seed); wr(8'h7B, d); check(latched, d);
      rd(8'h7B, d);
      {i_doze_timer, i_standby_timer, i_suspend_timer, i_housekeeping_timer, i_peripheral_timer} =
         39'({$random(seed), $random(seed)});
      wr(8'h88, 8'hFF); rd(8'h88, i_doze_timer[8:1]); rd(8'h89, {3'h0, i_standby_timer});
      rd(8'h8A, {1'b0, i_suspend_timer}); rd(8'h8B, i_housekeeping_timer[8:1]); rd(8'h8C, i_peripheral_timer[8:1]);
      $display("register tests done");
      // every state and duty code, the unused field randomised
      for (int s = 0; s < 8; s++) for (int c = 0; c < 8; c++) begin
         pd = s >= 1 && s <= 3;
         e = c == 0 ? 0 : c == 7 ? (pd ? 64 : 0) : 64 >> c;
         d = $random(seed); i_power_state_unit = 3'(s);
         wr(8'h7C, pd ? {d[7:5], 3'(c), d[1:0]} : {3'(c), d[4:0]}); repeat (3) cyc;
         h0 = halted; repeat (64) cyc; check(9'(halted - h0), 9'(e));
      end
      $display("duty sweep done");
      i_smi_pending = 1; i_power_state_unit = 3'h1; wr(8'h7C, 8'h1C); repeat (3) cyc;
      h0 = halted; repeat (64) cyc; check(9'(halted - h0), 9'h000);
      $display("smi test done");
      print_verdict;
   end
endmodule
bind stop_clock_modulation_regs stop_clock_modulation_regs_sva chk (.*);
`default_nettype wire
